/* File: verilog/isf_pkg.sv */
// shared constants and types for the interrupt status and flag block
package isf_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ISF_OFS_STATUS = 8'h00;
    localparam logic [7:0] ISF_OFS_RELOAD = 8'h04;
    localparam logic [7:0] ISF_OFS_FLAGS = 8'h08;
    localparam logic [7:0] ISF_OFS_CONTROL = 8'h0C;
    localparam logic [7:0] ISF_OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] ISF_OFS_EVT_MASK = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ISF_LEVEL_LSB = 8;
    localparam int ISF_LEVEL_MSB = 10;
    localparam int ISF_HANDLER_LSB = 0;
    localparam int ISF_HANDLER_MSB = 5;
    localparam int ISF_MULTI_BIT = 12;
    localparam int ISF_THR_LSB = 8;
    localparam int ISF_THR_MSB = 10;
    localparam int ISF_EVT_FLAG = 0;
    localparam int ISF_EVT_PROX = 1;
    localparam int ISF_EVT_PRESENT = 2;
    localparam int ISF_EVT_W = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ISF_RST_WORD = 32'h0000_0000;
    localparam logic [2:0] ISF_RST_LEVEL = 3'h0;
    localparam logic [5:0] ISF_RST_HANDLER = 6'h00;
    localparam logic [2:0] ISF_THR_OFF = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [2:0] level;
        logic [5:0] handler;
    } isf_present_t;

    // one request per source, msb first
    typedef struct packed {
        logic twowire_one_master_flag;
        logic twowire_one_slave_flag;
        logic twowire_one_collision_flag;
        logic async_one_transmit_flag;
        logic async_one_receive_flag;
        logic async_one_error_flag;
        logic sync_one_receive_flag;
        logic sync_one_transmit_flag;
        logic sync_one_error_flag;
        logic compare_five_flag;
        logic capture_five_flag;
        logic timer_five_flag;
        logic pin_irq_four_flag;
        logic compare_four_flag;
        logic capture_four_flag;
        logic timer_four_flag;
        logic pin_irq_three_flag;
        logic compare_three_flag;
        logic capture_three_flag;
        logic timer_three_flag;
        logic pin_irq_two_flag;
        logic compare_two_flag;
        logic capture_two_flag;
        logic timer_two_flag;
        logic pin_irq_one_flag;
        logic compare_one_flag;
        logic capture_one_flag;
        logic timer_one_flag;
        logic pin_irq_zero_flag;
        logic core_soft_one_flag;
        logic core_soft_zero_flag;
        logic core_timer_flag;
    } isf_flags_t;

endpackage

/* File: verilog/isf_top.sv */
// interrupt status, proximity reload and first request flag registers
`timescale 1ns/10ps
module isf_top (
    // clock, reset, enable
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // request sources and dispatch
    input isf_pkg::isf_flags_t EVENTS,
    input isf_pkg::isf_present_t PRESENT,
    // proximity timer side and dispatch select
    output logic PROX_START,
    output logic [31:0] PROX_RELOAD,
    output logic MULTI_ENTRY,
    // interrupt
    output logic IRQ
);
    import isf_pkg::*;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic access;
    logic wr;
    logic mapped;
    logic setup;

    always_comb begin
        mapped = (PADDR == ISF_OFS_STATUS) || (PADDR == ISF_OFS_RELOAD) ||
                 (PADDR == ISF_OFS_FLAGS) || (PADDR == ISF_OFS_CONTROL) ||
                 (PADDR == ISF_OFS_EVT_STAT) || (PADDR == ISF_OFS_EVT_MASK);
        // held off while frozen so no write lands on a stalled block
        PREADY = CE;
        access = PSEL && PENABLE && CE;
        wr = access && PWRITE && mapped;
        setup = PSEL && !PENABLE && CE;
        PSLVERR = access && !mapped;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0] level_reg, level_next;
    logic [5:0] handler_reg, handler_next;
    logic [31:0] reload_reg, reload_next;
    isf_flags_t flags_reg, flags_next;
    logic multi_reg, multi_next;
    logic [2:0] thr_reg, thr_next;
    logic [ISF_EVT_W-1:0] evt_stat_reg, evt_stat_next;
    logic [ISF_EVT_W-1:0] evt_mask_reg, evt_mask_next;
    logic prox_reg, prox_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] status_word;
    logic [31:0] control_word;
    logic [ISF_EVT_W-1:0] evt_raise;
    logic prox_hit;

    always_comb begin
        status_word = ISF_RST_WORD;
        // reserved bits stay zero
        status_word[ISF_LEVEL_MSB:ISF_LEVEL_LSB] = level_reg;
        status_word[ISF_HANDLER_MSB:ISF_HANDLER_LSB] = handler_reg;
        control_word = ISF_RST_WORD;
        control_word[ISF_MULTI_BIT] = multi_reg;
        control_word[ISF_THR_MSB:ISF_THR_LSB] = thr_reg;
        // group priority at or below a nonzero threshold starts the timer
        prox_hit = PRESENT.valid && (thr_reg != ISF_THR_OFF) && (PRESENT.level <= thr_reg);
    end

    always_comb begin
        level_next = level_reg;
        handler_next = handler_reg;
        reload_next = reload_reg;
        multi_next = multi_reg;
        thr_next = thr_reg;
        evt_mask_next = evt_mask_reg;
        prox_next = 1'b0;
        rdata_next = rdata_reg;
        if (PRESENT.valid) begin
            level_next = PRESENT.level;
            // single-entry dispatch shares handler zero
            handler_next = multi_reg ? PRESENT.handler : ISF_RST_HANDLER;
        end
        prox_next = prox_hit;
        // a write takes the whole word, then events are or-ed back in
        flags_next = flags_reg | EVENTS;
        if (wr && (PADDR == ISF_OFS_FLAGS)) begin
            flags_next = isf_flags_t'(PWDATA) | EVENTS;
        end
        if (wr && (PADDR == ISF_OFS_RELOAD)) begin
            reload_next = PWDATA;
        end
        if (wr && (PADDR == ISF_OFS_CONTROL)) begin
            multi_next = PWDATA[ISF_MULTI_BIT];
            thr_next = PWDATA[ISF_THR_MSB:ISF_THR_LSB];
        end
        if (wr && (PADDR == ISF_OFS_EVT_MASK)) begin
            evt_mask_next = PWDATA[ISF_EVT_W-1:0];
        end
        evt_raise = '0;
        evt_raise[ISF_EVT_FLAG] = |EVENTS;
        evt_raise[ISF_EVT_PROX] = prox_hit;
        evt_raise[ISF_EVT_PRESENT] = PRESENT.valid;
        // set beats a same-cycle write-one-to-clear
        evt_stat_next = evt_stat_reg | evt_raise;
        if (wr && (PADDR == ISF_OFS_EVT_STAT)) begin
            evt_stat_next = (evt_stat_reg & ~PWDATA[ISF_EVT_W-1:0]) | evt_raise;
        end
        // read data captured in setup, answered in access
        if (setup) begin
            unique case (PADDR)
                ISF_OFS_STATUS: rdata_next = status_word;
                ISF_OFS_RELOAD: rdata_next = reload_reg;
                ISF_OFS_FLAGS: rdata_next = flags_reg;
                ISF_OFS_CONTROL: rdata_next = control_word;
                ISF_OFS_EVT_STAT: rdata_next = {29'h0000_0000, evt_stat_reg};
                ISF_OFS_EVT_MASK: rdata_next = {29'h0000_0000, evt_mask_reg};
                default: rdata_next = ISF_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            level_reg <= ISF_RST_LEVEL;
            handler_reg <= ISF_RST_HANDLER;
            reload_reg <= ISF_RST_WORD;
            flags_reg <= isf_flags_t'(ISF_RST_WORD);
            multi_reg <= 1'b0;
            thr_reg <= ISF_THR_OFF;
            evt_stat_reg <= '0;
            evt_mask_reg <= '0;
            prox_reg <= 1'b0;
            rdata_reg <= ISF_RST_WORD;
        end else if (CE) begin
            level_reg <= level_next;
            handler_reg <= handler_next;
            reload_reg <= reload_next;
            flags_reg <= flags_next;
            multi_reg <= multi_next;
            thr_reg <= thr_next;
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
            prox_reg <= prox_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        PRDATA = rdata_reg;
        PROX_START = prox_reg;
        PROX_RELOAD = reload_reg;
        MULTI_ENTRY = multi_reg;
        IRQ = |(evt_stat_reg & evt_mask_reg);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_flag_write;
        CE && PSEL && PENABLE && PWRITE && (PADDR == ISF_OFS_FLAGS);
    endsequence

    sequence s_present_single;
        CE && PRESENT.valid && !multi_reg;
    endsequence

    property p_level_capture;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PRESENT.valid |=> status_word[10:8] == $past(PRESENT.level);
    endproperty
    a_level_capture: assert property (p_level_capture) else $error("level not captured");

    property p_handler_multi;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PRESENT.valid && multi_reg |=> status_word[5:0] == $past(PRESENT.handler);
    endproperty
    a_handler_multi: assert property (p_handler_multi) else $error("handler not captured");

    property p_handler_single;
        @(posedge MCLK) disable iff (SYS_RST)
        s_present_single |=> (handler_reg == ISF_RST_HANDLER) ##1
            (!$past(CE) || ($past(PRESENT.valid) && $past(multi_reg)) ||
            handler_reg == ISF_RST_HANDLER);
    endproperty
    a_handler_single: assert property (p_handler_single) else $error("single entry not shared");

    property p_reserved_zero;
        @(posedge MCLK) disable iff (SYS_RST)
        status_word[31:11] == 21'h00_0000 && status_word[7:6] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

    property p_reload_write;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && PENABLE && PWRITE && PADDR == ISF_OFS_RELOAD |=> PROX_RELOAD == $past(PWDATA);
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload not written");

    property p_flag_event;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && (EVENTS != '0) |=> (flags_reg & $past(EVENTS)) == $past(EVENTS);
    endproperty
    a_flag_event: assert property (p_flag_event) else $error("event flag lost");

    property p_flag_sticky;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && !(PSEL && PENABLE && PWRITE && PADDR == ISF_OFS_FLAGS)
        |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");

    property p_flag_write;
        @(posedge MCLK) disable iff (SYS_RST)
        s_flag_write ##0 (EVENTS == '0) |=> flags_reg == $past(PWDATA);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write mismatch");

    property p_prox_start;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PRESENT.valid && thr_reg != 3'h0 && PRESENT.level <= thr_reg |=> PROX_START;
    endproperty
    a_prox_start: assert property (p_prox_start) else $error("proximity not started");

    property p_prox_off;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && thr_reg == 3'h0 |=> !PROX_START;
    endproperty
    a_prox_off: assert property (p_prox_off) else $error("proximity started while off");

    property p_irq_level;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PRESENT.valid && evt_mask_reg[ISF_EVT_PRESENT] |=> IRQ ##1 (IRQ || $past(wr));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not held");

    property p_irq_off;
        @(posedge MCLK) disable iff (SYS_RST)
        evt_mask_reg == '0 |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while fully masked");

    property p_ready_frozen;
        @(posedge MCLK) disable iff (SYS_RST)
        !CE |-> !PREADY;
    endproperty
    a_ready_frozen: assert property (p_ready_frozen) else $error("ready while frozen");

    property p_slverr_bad;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && PENABLE && PADDR != ISF_OFS_STATUS && PADDR != ISF_OFS_RELOAD &&
        PADDR != ISF_OFS_FLAGS && PADDR != ISF_OFS_CONTROL &&
        PADDR != ISF_OFS_EVT_STAT && PADDR != ISF_OFS_EVT_MASK |-> PSLVERR;
    endproperty
    a_slverr_bad: assert property (p_slverr_bad) else $error("bad address unflagged");

    property p_slverr_idle;
        @(posedge MCLK) disable iff (SYS_RST)
        !(PSEL && PENABLE) |-> !PSLVERR;
    endproperty
    a_slverr_idle: assert property (p_slverr_idle) else $error("error outside access");

    // a stalled block must neither lose nor gain state
    property p_freeze_regs;
        @(posedge MCLK) disable iff (SYS_RST)
        !CE |=> $stable(flags_reg) && $stable(reload_reg) && $stable(evt_stat_reg);
    endproperty
    a_freeze_regs: assert property (p_freeze_regs) else $error("state moved while frozen");

    property p_freeze_status;
        @(posedge MCLK) disable iff (SYS_RST)
        !CE |=> $stable(level_reg) && $stable(handler_reg) && $stable(PRDATA);
    endproperty
    a_freeze_status: assert property (p_freeze_status) else $error("status moved while frozen");

    property p_rdata_reload;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && !PENABLE && PADDR == ISF_OFS_RELOAD |=> PRDATA == $past(reload_reg);
    endproperty
    a_rdata_reload: assert property (p_rdata_reload) else $error("reload read mismatch");

    property p_rdata_flags;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && !PENABLE && PADDR == ISF_OFS_FLAGS |=> PRDATA == $past(flags_reg);
    endproperty
    a_rdata_flags: assert property (p_rdata_flags) else $error("flag read mismatch");

    property p_rdata_status;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && !PENABLE && PADDR == ISF_OFS_STATUS
        |=> PRDATA == {21'h00_0000, $past(level_reg), 2'h0, $past(handler_reg)};
    endproperty
    a_rdata_status: assert property (p_rdata_status) else $error("status read mismatch");

    property p_status_ro;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && PENABLE && PWRITE && PADDR == ISF_OFS_STATUS && !PRESENT.valid
        |=> $stable(level_reg) && $stable(handler_reg);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status changed by write");

    property p_evt_clear;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && PENABLE && PWRITE && PADDR == ISF_OFS_EVT_STAT &&
        PWDATA[ISF_EVT_FLAG] && EVENTS == '0 |=> !evt_stat_reg[ISF_EVT_FLAG];
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event status not cleared");

    property p_evt_set;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && EVENTS != '0 |=> evt_stat_reg[ISF_EVT_FLAG];
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("event status not set");

    property p_prox_pulse;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && !PRESENT.valid |=> !PROX_START;
    endproperty
    a_prox_pulse: assert property (p_prox_pulse) else $error("proximity start without request");

    property p_multi_write;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && PSEL && PENABLE && PWRITE && PADDR == ISF_OFS_CONTROL
        |=> MULTI_ENTRY == $past(PWDATA[ISF_MULTI_BIT]);
    endproperty
    a_multi_write: assert property (p_multi_write) else $error("dispatch select not written");

endmodule

/* File: bench/isf_cpu_model.sv */
// cpu core stand-in that dispatches requests to the controller
`timescale 1ns/10ps
module isf_cpu_model
    import isf_pkg::*;
(
    // clock
    input wire logic mclk,
    // dispatch towards the controller
    output isf_pkg::isf_present_t present
);
    initial begin
        present = '0;
    end
    // one-cycle handover; fields inverted afterwards so stale values never look held
    task automatic send(input logic [2:0] lvl, input logic [5:0] hnd);
        present <= '{valid: 1'b1, level: lvl, handler: hnd};
        @(posedge mclk);
        present <= '{valid: 1'b0, level: ~lvl, handler: ~hnd};
    endtask
endmodule

/* File: bench/isf_top_tb.sv */
// self-checking bench for the status, reload and request flag registers
`timescale 1ns/10ps
module isf_top_tb;
    import isf_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prox_start;
    logic [31:0] prox_reload;
    logic multi_entry;
    logic irq;
    isf_flags_t events = '0;
    isf_present_t present;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] rv;
    logic ev_err;
    always #2.5 mclk = ~mclk;
    isf_top u_isf_top (.MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EVENTS(events), .PRESENT(present),
        .PROX_START(prox_start), .PROX_RELOAD(prox_reload), .MULTI_ENTRY(multi_entry),
        .IRQ(irq));
    isf_cpu_model u_isf_cpu_model (.mclk(mclk), .present(present));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // entered just after a rising edge; returns just after one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        // answer taken at the edge that sees pready high
        rv = prdata;
        ev_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp(what, rv, exp);
    endtask
    task automatic ev(input logic [31:0] v);
        events <= isf_flags_t'(v);
        @(posedge mclk);
        events <= '0;
        @(posedge mclk);
    endtask
    // sample a single-cycle output mid-cycle, then realign to the rising edge
    task automatic pin(input string what, input logic exp);
        @(negedge mclk);
        cmp(what, 32'(prox_start), 32'(exp));
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk("status", ISF_OFS_STATUS, 32'h0000_0000);
        cmp("slverr ok", 32'(ev_err), 32'h0000_0000);
        chk("reload", ISF_OFS_RELOAD, 32'h0000_0000);
        chk("flags", ISF_OFS_FLAGS, 32'h0000_0000);
        apb(1'b1, ISF_OFS_RELOAD, 32'hA5C3_0F96);
        chk("reload", ISF_OFS_RELOAD, 32'hA5C3_0F96);
        cmp("reload out", prox_reload, 32'hA5C3_0F96);
        for (int i = 0; i < 32; i++) begin
            ev(32'h0000_0001 << i);
            chk("flag bit", ISF_OFS_FLAGS, 32'h0000_0001 << i);
            apb(1'b1, ISF_OFS_FLAGS, 32'h0000_0000);
        end
        chk("flags", ISF_OFS_FLAGS, 32'h0000_0000);
        ev(32'h0000_0020);
        repeat (5) @(posedge mclk);
        chk("sticky", ISF_OFS_FLAGS, 32'h0000_0020);
        apb(1'b1, ISF_OFS_FLAGS, 32'h8000_0001);
        chk("flag write", ISF_OFS_FLAGS, 32'h8000_0001);
        // every threshold against every level, single and multi entry
        for (int t = 0; t < 8; t++) begin
            for (int m = 0; m < 2; m++) begin
                apb(1'b1, ISF_OFS_CONTROL, (32'(m) << 12) | (32'(t) << 8));
                cmp("multi", 32'(multi_entry), 32'(m));
                for (int l = 0; l < 8; l++) begin
                    u_isf_cpu_model.send(3'(l), 6'(l * 7 + t + 1));
                    pin("prox", t != 0 && l <= t);
                    pin("prox pulse", 1'b0);
                end
                chk("status", ISF_OFS_STATUS, 32'h0000_0700 | (m ? 32'(50 + t) : 0));
            end
        end
        apb(1'b1, ISF_OFS_STATUS, 32'hFFFF_FFFF);
        chk("status ro", ISF_OFS_STATUS, 32'h0000_0739);
        apb(1'b1, ISF_OFS_EVT_MASK, 32'h0000_0000);
        apb(1'b1, ISF_OFS_EVT_STAT, 32'h0000_0007);
        ev(32'h0000_0100);
        chk("evt stat", ISF_OFS_EVT_STAT, 32'h0000_0001);
        cmp("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, ISF_OFS_EVT_MASK, 32'h0000_0001);
        cmp("irq", 32'(irq), 32'h0000_0001);
        apb(1'b1, ISF_OFS_EVT_STAT, 32'h0000_0001);
        cmp("irq clear", 32'(irq), 32'h0000_0000);
        chk("evt stat", ISF_OFS_EVT_STAT, 32'h0000_0000);
        // presented request under threshold seven also starts the timer
        apb(1'b1, ISF_OFS_EVT_MASK, 32'h0000_0004);
        u_isf_cpu_model.send(3'h2, 6'h05);
        @(posedge mclk);
        cmp("irq present", 32'(irq), 32'h0000_0001);
        chk("evt stat", ISF_OFS_EVT_STAT, 32'h0000_0006);
        apb(1'b1, ISF_OFS_EVT_STAT, 32'h0000_0006);
        cmp("irq clear", 32'(irq), 32'h0000_0000);
        apb(1'b1, 8'h20, 32'h1234_5678);
        cmp("slverr", 32'(ev_err), 32'h0000_0001);
        chk("unmapped", 8'h20, 32'h0000_0000);
        cmp("slverr", 32'(ev_err), 32'h0000_0001);
        // events while frozen must not reach the flags
        ce <= 1'b0;
        events <= isf_flags_t'(32'h0000_0002);
        repeat (3) @(posedge mclk);
        events <= '0;
        ce <= 1'b1;
        @(posedge mclk);
        chk("frozen", ISF_OFS_FLAGS, 32'h8000_0101);
        // second reset in mid-run
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk("reload rst", ISF_OFS_RELOAD, 32'h0000_0000);
        chk("flags rst", ISF_OFS_FLAGS, 32'h0000_0000);
        chk("status rst", ISF_OFS_STATUS, 32'h0000_0000);
        cmp("multi rst", 32'(multi_entry), 32'h0000_0000);
        cmp("irq rst", 32'(irq), 32'h0000_0000);
        final_report();
    end
endmodule
